// [rtl/bscr_pkg.sv]
/*
  Package for the board system control register bank: register offsets,
  field positions, reset values, command encodings and carrier structs.
  Assumes a 32-bit register port with word-aligned byte addresses.
*/
package bscr_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_IDENT      = 8'h00;
  localparam logic [7:0] OFF_SWITCH     = 8'h04;
  localparam logic [7:0] OFF_LED        = 8'h08;
  localparam logic [7:0] OFF_CNT100     = 8'h24;
  localparam logic [7:0] OFF_FLAGS      = 8'h30;
  localparam logic [7:0] OFF_FLAGCLR    = 8'h34;
  localparam logic [7:0] OFF_MEDIA      = 8'h40;
  localparam logic [7:0] OFF_CARD       = 8'h48;
  localparam logic [7:0] OFF_CNT24M     = 8'h5C;
  localparam logic [7:0] OFF_CPUID0     = 8'h84;
  localparam logic [7:0] OFF_CPUID1     = 8'h88;
  localparam logic [7:0] OFF_CFGDATA    = 8'hA0;
  localparam logic [7:0] OFF_CFGCTRL    = 8'hA4;
  localparam logic [7:0] OFF_CFGSTAT    = 8'hA8;

  // reset values
  localparam logic [31:0] IDENT_RST     = 32'h1234_5600; // arbitrary value
  localparam logic [31:0] CPUID0_RST    = 32'h0000_0A01; // arbitrary value
  localparam logic [31:0] CPUID1_RST    = 32'h0000_0A02; // arbitrary value
  localparam logic [7:0]  SWITCH_RST    = 8'h00;
  localparam logic [1:0]  MEDIA_RST     = 2'h1;

  // media source encodings
  localparam logic [1:0]  MEDIA_MOTHER  = 2'h0;
  localparam logic [1:0]  MEDIA_DAUGHT1 = 2'h1;
  localparam logic [1:0]  MEDIA_DAUGHT2 = 2'h2;

  // transfer control fields
  localparam int          CTRL_START    = 31;
  localparam int          CTRL_WRITE    = 30;
  localparam int          CTRL_FN_LO    = 20;
  localparam logic [5:0]  FN_SHUTDOWN   = 6'h08;
  localparam logic [5:0]  FN_REBOOT     = 6'h09;
  localparam int          STAT_DONE     = 0;

  // board config bus strobe
  localparam logic [31:0] CFG_BUS_CYC   = 32'h4;

  typedef struct packed {
    logic        en;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bscr_req_s;

  typedef struct packed {
    logic        valid;
    logic        wr;
    logic [5:0]  fn;
    logic [31:0] data;
  } bscr_cfg_s;

endpackage : bscr_pkg

// [rtl/bscr_cfgport.sv]
/*
  Board config bus master: one transfer per start, strobed for a fixed
  number of cycles on both board ports. Assumes the request is a single
  cycle pulse and is not repeated while busy.
*/
`timescale 1ns/100ps
module bscr_cfgport (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // request
  input  wire bscr_pkg::bscr_cfg_s req,
  output logic                     busy,
  output logic                     done_pulse,
  // board config bus ports
  output bscr_pkg::bscr_cfg_s      board_config_bus_ports [2]
);

  logic [31:0]         cnt_q;
  bscr_pkg::bscr_cfg_s hold_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      hold_q <= '0;
    end else if (req.valid && cnt_q == '0) begin
      cnt_q  <= bscr_pkg::CFG_BUS_CYC;
      hold_q <= req;
    end else if (cnt_q != '0) begin
      cnt_q  <= cnt_q - 32'h1;
      if (cnt_q == 32'h1) hold_q.valid <= 1'b0;
    end
  end

  assign busy       = (cnt_q != '0);
  assign done_pulse = (cnt_q == 32'h1);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_port
      assign board_config_bus_ports[g] = hold_q;
    end
  endgenerate

endmodule : bscr_cfgport

// [rtl/bscr_top.sv]
/*
  Board system control register bank: identity, switches, LEDs, two
  reference counters, flags, media source select, processor IDs, board
  config transfers, reset and shutdown requests. Assumes the register
  port is driven synchronously to clk_sys; reference clocks and switches
  are asynchronous and get synchronised.
*/
`timescale 1ns/100ps
module bscr_top #(
  parameter logic [7:0] USER_SWITCHES_VALUE = bscr_pkg::SWITCH_RST,
  parameter logic [1:0] MEDIA_SOURCE_DEFAULT = bscr_pkg::MEDIA_RST,
  parameter logic [31:0] SITE_ONE_ID = bscr_pkg::CPUID0_RST,
  parameter logic [31:0] SITE_TWO_ID = bscr_pkg::CPUID1_RST,
  parameter bit          EXIT_ON_SHUTDOWN = 1'b0
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // register port
  input  wire bscr_pkg::bscr_req_s reg_req,
  output logic [31:0]              reg_rdata,
  // pins
  input  wire logic [7:0]          user_switch_pins,
  input  wire logic                ref_clk_24m,
  input  wire logic                ref_clk_100,
  input  wire logic                card_present,
  input  wire logic [31:0]         media_in [3],
  output logic [31:0]              display_out,
  output logic [7:0]               led_out,
  output logic [7:0]               led_status,
  output logic [7:0]               switch_state,
  output logic                     system_reset_req,
  output logic                     shutdown_req,
  output bscr_pkg::bscr_cfg_s      board_config_bus_ports [2]
);

  // two-flop synchronisers for all asynchronous inputs
  logic [10:0] s1_q, s2_q, s3_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {card_present, ref_clk_100, ref_clk_24m, user_switch_pins};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // edge detect uses second and third stages only
  wire edge_24m = s2_q[8] & ~s3_q[8];
  wire edge_100 = s2_q[9] & ~s3_q[9];
  wire card_sync = s2_q[10];

  // registers
  logic [31:0] ident_q, led_q, flags_q, cnt24_q, cnt100_q;
  logic [31:0] cpuid0_q, cpuid1_q, cfgdata_q, cfgctrl_q, cfgstat_q;
  logic [7:0]  sw_q;
  logic [1:0]  media_q;
  logic        loaded_q, sysrst_q, shut_q, busy;
  logic        done_pulse;
  bscr_pkg::bscr_cfg_s cfg_req;

  wire wr = reg_req.en & reg_req.wr;
  wire [31:0] wd = reg_req.wdata;
  wire wr_ident  = wr && reg_req.addr == bscr_pkg::OFF_IDENT;
  wire wr_sw     = wr && reg_req.addr == bscr_pkg::OFF_SWITCH;
  wire wr_led    = wr && reg_req.addr == bscr_pkg::OFF_LED;
  wire wr_flags  = wr && reg_req.addr == bscr_pkg::OFF_FLAGS;
  wire wr_fclr   = wr && reg_req.addr == bscr_pkg::OFF_FLAGCLR;
  wire wr_media  = wr && reg_req.addr == bscr_pkg::OFF_MEDIA;
  wire wr_id0    = wr && reg_req.addr == bscr_pkg::OFF_CPUID0;
  wire wr_id1    = wr && reg_req.addr == bscr_pkg::OFF_CPUID1;
  wire wr_cdata  = wr && reg_req.addr == bscr_pkg::OFF_CFGDATA;
  wire wr_cctrl  = wr && reg_req.addr == bscr_pkg::OFF_CFGCTRL;
  wire wr_cstat  = wr && reg_req.addr == bscr_pkg::OFF_CFGSTAT;
  wire start     = wr_cctrl && wd[bscr_pkg::CTRL_START] && !busy;
  wire [5:0] fn  = wd[bscr_pkg::CTRL_FN_LO +: 6];
  wire media_ok  = wd[1:0] <= bscr_pkg::MEDIA_DAUGHT2;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ident_q   <= bscr_pkg::IDENT_RST;
      led_q     <= '0;
      flags_q   <= '0;
      cnt24_q   <= '0;
      cnt100_q  <= '0;
      cpuid0_q  <= SITE_ONE_ID;
      cpuid1_q  <= SITE_TWO_ID;
      cfgdata_q <= '0;
      cfgctrl_q <= '0;
      cfgstat_q <= '0;
      sw_q      <= USER_SWITCHES_VALUE;
      media_q   <= MEDIA_SOURCE_DEFAULT;
      loaded_q  <= 1'b0;
      sysrst_q  <= 1'b0;
      shut_q    <= 1'b0;
    end else begin
      if (!loaded_q) begin
        // build values caught on the first edge after release
        loaded_q <= 1'b1;
        sw_q     <= USER_SWITCHES_VALUE;
        media_q  <= MEDIA_SOURCE_DEFAULT;
        cpuid0_q <= SITE_ONE_ID;
        cpuid1_q <= SITE_TWO_ID;
      end else begin
        if (wr_sw) sw_q <= wd[7:0];
        else if (s2_q[7:0] != s3_q[7:0]) sw_q <= s2_q[7:0];
        if (wr_media && media_ok) media_q <= wd[1:0];
        if (wr_id0) cpuid0_q <= wd;
        if (wr_id1) cpuid1_q <= wd;
      end
      if (wr_ident) ident_q <= wd;
      if (wr_led) led_q <= {24'h0, wd[7:0]};
      if (wr_flags) flags_q <= flags_q | wd;
      else if (wr_fclr) flags_q <= flags_q & ~wd;
      if (edge_24m) cnt24_q <= cnt24_q + 32'h1;
      if (edge_100) cnt100_q <= cnt100_q + 32'h1;
      if (wr_cdata) cfgdata_q <= wd;
      if (start) cfgctrl_q <= wd;
      else if (done_pulse) cfgctrl_q[bscr_pkg::CTRL_START] <= 1'b0;
      // done sets over a software clear
      if (done_pulse) cfgstat_q[bscr_pkg::STAT_DONE] <= 1'b1;
      else if (start || wr_cstat) cfgstat_q <= '0;
      if (start && fn == bscr_pkg::FN_REBOOT) sysrst_q <= 1'b1;
      if (start && fn == bscr_pkg::FN_SHUTDOWN && EXIT_ON_SHUTDOWN)
        shut_q <= 1'b1;
    end
  end

  assign cfg_req = '{valid: start, wr: wd[bscr_pkg::CTRL_WRITE],
                     fn: fn, data: cfgdata_q};

  bscr_cfgport u_cfgport (
    .clk_sys                (clk_sys),
    .rst                    (rst),
    .req                    (cfg_req),
    .busy                   (busy),
    .done_pulse             (done_pulse),
    .board_config_bus_ports (board_config_bus_ports)
  );

  // read mux; unmapped offsets read zero
  logic [31:0] rd_d;
  always_comb begin
    case (reg_req.addr)
      bscr_pkg::OFF_IDENT:   rd_d = ident_q;
      bscr_pkg::OFF_SWITCH:  rd_d = {24'h0, sw_q};
      bscr_pkg::OFF_LED:     rd_d = led_q;
      bscr_pkg::OFF_CNT100:  rd_d = cnt100_q;
      bscr_pkg::OFF_FLAGS:   rd_d = flags_q;
      bscr_pkg::OFF_MEDIA:   rd_d = {30'h0, media_q};
      bscr_pkg::OFF_CARD:    rd_d = {31'h0, card_sync};
      bscr_pkg::OFF_CNT24M:  rd_d = cnt24_q;
      bscr_pkg::OFF_CPUID0:  rd_d = cpuid0_q;
      bscr_pkg::OFF_CPUID1:  rd_d = cpuid1_q;
      bscr_pkg::OFF_CFGDATA: rd_d = cfgdata_q;
      bscr_pkg::OFF_CFGCTRL: rd_d = cfgctrl_q;
      bscr_pkg::OFF_CFGSTAT: rd_d = cfgstat_q;
      default:               rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) reg_rdata <= '0;
    else reg_rdata <= (reg_req.en && !reg_req.wr) ? rd_d : 32'h0;
  end

  logic [31:0] disp_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) disp_q <= '0;
    else disp_q <= (media_q <= bscr_pkg::MEDIA_DAUGHT2) ?
                   media_in[media_q] : 32'h0;
  end

  assign display_out      = disp_q;
  assign led_out          = led_q[7:0];
  assign led_status       = led_q[7:0];
  assign switch_state     = sw_q;
  assign system_reset_req = sysrst_q;
  assign shutdown_req     = shut_q;

  property p_led;
    @(posedge clk_sys) disable iff (rst)
      wr_led |=> led_out == $past(wd[7:0]);
  endproperty
  a_led: assert property (p_led) else $error("led mismatch");
  property p_ledst;
    @(posedge clk_sys) disable iff (rst) led_status == led_out;
  endproperty
  a_ledst: assert property (p_ledst) else $error("led status");
  property p_sw;
    @(posedge clk_sys) disable iff (rst)
      reg_req.en && !reg_req.wr && reg_req.addr == bscr_pkg::OFF_SWITCH
      |=> reg_rdata == {24'h0, $past(sw_q)};
  endproperty
  a_sw: assert property (p_sw) else $error("switch read");
  property p_reb;
    @(posedge clk_sys) disable iff (rst)
      start && fn == bscr_pkg::FN_REBOOT |=> system_reset_req;
  endproperty
  a_reb: assert property (p_reb) else $error("no reset");
  property p_shut;
    @(posedge clk_sys) disable iff (rst)
      !EXIT_ON_SHUTDOWN |-> !shutdown_req;
  endproperty
  a_shut: assert property (p_shut) else $error("bad shutdown");
  property p_shut_go;
    @(posedge clk_sys) disable iff (rst)
      start && fn == bscr_pkg::FN_SHUTDOWN
      |=> shutdown_req == EXIT_ON_SHUTDOWN;
  endproperty
  a_shut_go: assert property (p_shut_go) else $error("shutdown req");
  property p_cnt;
    @(posedge clk_sys) disable iff (rst)
      edge_24m |=> cnt24_q == $past(cnt24_q) + 32'h1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter");
  property p_fclr;
    @(posedge clk_sys) disable iff (rst)
      wr_fclr |=> flags_q == ($past(flags_q) & ~$past(wd));
  endproperty
  a_fclr: assert property (p_fclr) else $error("flag clear");
  property p_unm;
    @(posedge clk_sys) disable iff (rst)
      reg_req.en && !reg_req.wr && reg_req.addr == 8'hFC
      |=> reg_rdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped");
  property p_cfg;
    @(posedge clk_sys) disable iff (rst)
      start |=> board_config_bus_ports[0].valid [*4] ##1 cfgstat_q[0];
  endproperty
  a_cfg: assert property (p_cfg) else $error("cfg transfer");
  property p_med;
    @(posedge clk_sys) disable iff (rst) media_q <= bscr_pkg::MEDIA_DAUGHT2;
  endproperty
  a_med: assert property (p_med) else $error("media select");
  property p_med_ref;
    @(posedge clk_sys) disable iff (rst)
      wr_media && wd[1:0] > bscr_pkg::MEDIA_DAUGHT2 |=> $stable(media_q);
  endproperty
  a_med_ref: assert property (p_med_ref) else $error("media refused");

endmodule : bscr_top

// [test/bscr_env_model.sv]
/*
  Board-side environment of the system control register bank: the two
  reference clocks, the three media bus sources and card presence.
  Assumes the register bank samples the reference clocks on clk_sys.
*/
`timescale 1ns/100ps
module bscr_env_model (
  // reference clocks
  output logic        ref_clk_24m,
  output logic        ref_clk_100,
  // media sources and card
  output logic [31:0] media_in [3],
  output logic        card_present
);
  // scaled down so both stay slower than a quarter of clk_sys
  initial ref_clk_24m = 1'b0;
  initial ref_clk_100 = 1'b0;
  always #150 ref_clk_24m = ~ref_clk_24m;
  always #500 ref_clk_100 = ~ref_clk_100;

  // each source carries its own index so a wrong select shows up
  assign media_in[0]  = 32'hC0DE_0000;
  assign media_in[1]  = 32'hC0DE_0001;
  assign media_in[2]  = 32'hC0DE_0002;
  assign card_present = 1'b1;
endmodule : bscr_env_model

// [test/tb_top.sv]
/*
  Self-checking bench for the register bank: register port tasks and
  directed tests. Assumes the environment model drives the board pins other than the user switches.
*/
`timescale 1ns/100ps
module tb_top;
  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  bscr_pkg::bscr_req_s   reg_req = '0;
  logic [31:0]           reg_rdata, display_out, rd, rd2;
  logic [7:0]            user_switch_pins = 8'h00;
  logic [7:0]            led_out, led_status, switch_state;
  logic                  ref_clk_24m, ref_clk_100, card_present;
  logic                  system_reset_req, shutdown_req;
  logic [31:0]           media_in [3];
  bscr_pkg::bscr_cfg_s   board_config_bus_ports [2];
  int                    fail_count = 0;
  int                    samples_checked = 0;

  always #25 clk_sys = ~clk_sys;

  bscr_env_model u_env (.ref_clk_24m, .ref_clk_100, .media_in,
                        .card_present);

  bscr_top #(.EXIT_ON_SHUTDOWN(1'b1)) u_dut (
    .clk_sys, .rst, .reg_req, .reg_rdata, .user_switch_pins,
    .ref_clk_24m, .ref_clk_100, .card_present, .media_in, .display_out,
    .led_out, .led_status, .switch_state, .system_reset_req,
    .shutdown_req, .board_config_bus_ports);

  // request held one cycle; read data taken just after the taking edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    reg_req <= '{en: 1'b1, wr: w, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req.en <= 1'b0;
    #1 q = reg_rdata;
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic cfg(input logic [5:0] fn, input logic w);
    bus(1'b1, bscr_pkg::OFF_CFGDATA, {16'h5A5A, 10'h0, fn}, rd);
    bus(1'b1, bscr_pkg::OFF_CFGCTRL, {1'b1, w, 4'h0, fn, 20'h0}, rd);
    @(posedge clk_sys);
    #1;
    chk({31'h0, board_config_bus_ports[0].valid}, 32'h1, "port0 vld");
    chk({31'h0, board_config_bus_ports[1].valid}, 32'h1, "port1 vld");
    chk({26'h0, board_config_bus_ports[0].fn}, {26'h0, fn}, "port fn");
    chk({31'h0, board_config_bus_ports[0].wr}, {31'h0, w}, "port wr");
    chk(board_config_bus_ports[1].data, {16'h5A5A, 10'h0, fn},
        "port data");
    repeat (6) @(posedge clk_sys);
    bus(1'b0, bscr_pkg::OFF_CFGSTAT, 32'h0, rd);
    chk({31'h0, rd[0]}, 32'h1, "cfg done");
    bus(1'b0, bscr_pkg::OFF_CFGCTRL, 32'h0, rd);
    chk({31'h0, rd[31]}, 32'h0, "start clr");
  endtask : cfg

  initial begin
    #100000;
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(display_out, 32'hC0DE_0001, "media dflt");
    chk({24'h0, switch_state}, 32'h0, "sw dflt");
    chk({24'h0, led_out}, 32'h0, "led dflt");
    bus(1'b0, bscr_pkg::OFF_IDENT, 32'h0, rd);
    chk(rd, bscr_pkg::IDENT_RST, "ident");
    bus(1'b0, bscr_pkg::OFF_CPUID0, 32'h0, rd);
    chk(rd, bscr_pkg::CPUID0_RST, "cpuid0");
    bus(1'b0, bscr_pkg::OFF_CPUID1, 32'h0, rd);
    chk(rd, bscr_pkg::CPUID1_RST, "cpuid1");
    $display("test reset values done");

    bus(1'b1, bscr_pkg::OFF_LED, 32'h0000_01A5, rd);
    bus(1'b0, bscr_pkg::OFF_LED, 32'h0, rd);
    chk({24'h0, rd[7:0]}, 32'hA5, "led read");
    chk({24'h0, led_out}, 32'hA5, "led pins");
    chk({24'h0, led_status}, 32'hA5, "led status");
    @(posedge clk_sys);
    user_switch_pins <= 8'h3C;
    repeat (4) @(posedge clk_sys);
    bus(1'b0, bscr_pkg::OFF_SWITCH, 32'h0, rd);
    chk({24'h0, rd[7:0]}, 32'h3C, "sw read");
    chk({24'h0, switch_state}, 32'h3C, "sw port");
    $display("test leds and switches done");

    for (int i = 0; i < 4; i++) begin
      bus(1'b1, bscr_pkg::OFF_MEDIA, i, rd);
      repeat (2) @(posedge clk_sys);
      #1;
      // value 3 is refused, so source 2 stays routed
      chk(display_out, 32'hC0DE_0000 + (i > 2 ? 2 : i), "media");
    end
    $display("test media select done");

    bus(1'b0, bscr_pkg::OFF_CNT24M, 32'h0, rd);
    repeat (40) @(posedge clk_sys);
    bus(1'b0, bscr_pkg::OFF_CNT24M, 32'h0, rd2);
    chk({31'h0, rd2 > rd}, 32'h1, "cnt24m");
    bus(1'b0, bscr_pkg::OFF_CNT100, 32'h0, rd);
    repeat (40) @(posedge clk_sys);
    bus(1'b0, bscr_pkg::OFF_CNT100, 32'h0, rd2);
    chk({31'h0, rd2 > rd}, 32'h1, "cnt100");
    $display("test counters done");

    bus(1'b1, bscr_pkg::OFF_FLAGS, 32'h0000_00FF, rd);
    bus(1'b1, bscr_pkg::OFF_FLAGCLR, 32'h0000_000F, rd);
    bus(1'b0, bscr_pkg::OFF_FLAGS, 32'h0, rd);
    chk(rd, 32'h0000_00F0, "flag clr");
    bus(1'b1, 8'hFC, 32'hFFFF_FFFF, rd);
    bus(1'b0, 8'hFC, 32'h0, rd);
    chk(rd, 32'h0, "unmapped");
    chk({24'h0, led_out}, 32'hA5, "no side eff");
    bus(1'b0, bscr_pkg::OFF_CARD, 32'h0, rd);
    chk({31'h0, rd[0]}, 32'h1, "card");
    $display("test flags and unmapped done");

    chk({31'h0, shutdown_req}, 32'h0, "shut idle");
    cfg(bscr_pkg::FN_SHUTDOWN, 1'b1);
    chk({31'h0, shutdown_req}, 32'h1, "shutdown");
    chk({31'h0, system_reset_req}, 32'h0, "rst idle");
    cfg(bscr_pkg::FN_REBOOT, 1'b0);
    chk({31'h0, system_reset_req}, 32'h1, "reboot");
    $display("test config transfers done");

    // mid-run reset: sticky requests and LEDs must drop
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({31'h0, system_reset_req}, 32'h0, "reboot cleared");
    chk({31'h0, shutdown_req}, 32'h0, "shutdown cleared");
    chk({24'h0, led_status}, 32'h0, "leds cleared");
    chk({31'h0, board_config_bus_ports[0].valid}, 32'h0, "port idle");
    bus(1'b0, bscr_pkg::OFF_CPUID0, 32'h0, rd);
    chk(rd, bscr_pkg::CPUID0_RST, "cpuid0 reload");
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : tb_top
